// file: verilog/csm_pkg.sv
// Purpose: constants for the configuration set manager
// Assumes: one clock, synchronous active-high reset, plain register port
// Notes: parameter words are abstract; the active set is a small array of words
//
// Overview of operation
// R01: Active parameter words live in flops and are rebuilt on every reset.
// R02: Three factory profiles are constants that no command can alter.
// R03: Standard profile has low gain and every automatic function off.
// R04: High-gain profile is standard with gain raised to six decibels.
// R05: Auto profile enables continuous auto gain and exposure, gain kept minimal.
// R06: The chosen default factory profile survives reset in the persistent store.
// R07: Exactly three user slots, held in the persistent store across reset.
// R08: The lookup table word is never written into a user slot.
// R09: Host picks slot 1 to 3, then save copies active words into it.
// R10: A save overwrites every stored word of the chosen slot.
// R11: Boot profile may be the default profile or any user slot.
// R12: After reset the chosen boot profile is copied into the active set.
// R13: The shipped default choice is the standard factory profile.
// R14: The default-profile choice is changed only while the device is idle.
// R15: Load copies the chosen user slot or default profile into the active set.
// R16: A load is accepted only while the device is idle.
// R17: A dedicated boot selector picks user slot 1, 2, 3 or default.
// R18: Requests refused while busy change nothing and raise a sticky flag; the code still takes user_sel and boot_sel from the refused write.
package csm_pkg;
  localparam int NUM_WORDS = 4;
  localparam int WORD_W = 16;
  localparam int NUM_SLOTS = 3;
  // Word positions inside a parameter set
  localparam logic [1:0] WORD_GAIN = 2'h0;
  localparam logic [1:0] WORD_GAIN_AUTO = 2'h1;
  localparam logic [1:0] WORD_EXPO_AUTO = 2'h2;
  localparam logic [1:0] WORD_LUT = 2'h3;
  // Gain in tenths of a decibel; auto modes 0 off, 2 continuous
  localparam logic [15:0] GAIN_LOW = 16'h0000;
  localparam logic [15:0] GAIN_6DB = 16'h003c;
  localparam logic [15:0] AUTO_OFF = 16'h0000;
  localparam logic [15:0] AUTO_CONT = 16'h0002;
  localparam logic [15:0] LUT_RESET = 16'h0000;
  // Selector encodings
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] FAC_STANDARD = 2'h0;
  localparam logic [1:0] FAC_HIGH_GAIN = 2'h1;
  localparam logic [1:0] FAC_AUTO = 2'h2;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_WADDR = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  // Control register bit positions
  localparam int CTRL_SEL_LO = 0;
  localparam int CTRL_BOOT_LO = 2;
  localparam int CTRL_FAC_LO = 4;
  localparam int CTRL_SAVE = 6;
  localparam int CTRL_LOAD = 7;
  localparam int CTRL_SETFAC = 8;
  localparam int CTRL_CLRERR = 9;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  typedef enum logic [1:0] {CSM_BOOT, CSM_IDLE, CSM_COPY} csm_state_type;
endpackage

// file: verilog/csm_factory_rom.sv
// Purpose: fixed factory profile lookup
// Assumes: purely combinational
// Notes: contents cannot be written by any path
`timescale 1ns/100ps
module csm_factory_rom (
  input wire logic [1:0] profile_i,
  input wire logic [1:0] word_i,
  output logic [15:0] data_o
);
  // Profiles are constants, so no command reaches them [R02]
  always_comb
  begin
    data_o = csm_pkg::AUTO_OFF; // [R03]
    if (word_i == csm_pkg::WORD_GAIN)
      data_o = (profile_i == csm_pkg::FAC_HIGH_GAIN) ? csm_pkg::GAIN_6DB : csm_pkg::GAIN_LOW; // [R04]
    else if ((word_i == csm_pkg::WORD_GAIN_AUTO) || (word_i == csm_pkg::WORD_EXPO_AUTO))
      data_o = (profile_i == csm_pkg::FAC_AUTO) ? csm_pkg::AUTO_CONT : csm_pkg::AUTO_OFF; // [R05]
    else if (word_i == csm_pkg::WORD_LUT)
      data_o = csm_pkg::LUT_RESET;
  end
endmodule

// file: verilog/csm_manager.sv
// Purpose: configuration set manager, top level
// Assumes: busy_i is high while acquisition runs or is pending
// Notes: persistent slots and choices reset only through nv_init_i, modelling power-proof storage
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
module csm_manager (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic nv_init_i,
  input wire logic busy_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [15:0] gain_o,
  output logic [15:0] gain_auto_o,
  output logic [15:0] expo_auto_o,
  output logic [15:0] lut_o,
  output logic ready_o,
  output logic reject_o
);
  localparam int NW = csm_pkg::NUM_WORDS;
  localparam int NS = csm_pkg::NUM_SLOTS;

  // Persistent store: three slots plus default and boot choices [R07]
  logic [15:0] slot [NS][NW];
  logic [1:0] fac_sel;
  logic [1:0] boot_sel;
  // Volatile state
  logic [15:0] active [NW];
  logic [1:0] user_sel;
  logic [1:0] copy_src;
  logic [1:0] word_idx;
  logic [3:0] edit_addr;
  logic reject;
  csm_pkg::csm_state_type state;
  csm_pkg::csm_state_type next_state;
  logic [1:0] next_copy_src;
  logic [1:0] next_word_idx;
  logic next_reject;
  logic [1:0] next_user_sel;
  logic [1:0] next_fac_sel;
  logic [1:0] next_boot_sel;
  logic [3:0] next_edit_addr;
  logic [15:0] next_rdata;
  logic [15:0] fac_word;
  logic [15:0] src_word;
  logic do_save;
  logic wr_ctrl;
  logic idle;
  // High when a request is refused this cycle, so it can override a clear
  logic refused;

  csm_factory_rom u_rom (
    .profile_i(fac_sel),
    .word_i(word_idx),
    .data_o(fac_word)
  );

  assign idle = (state == csm_pkg::CSM_IDLE) && !busy_i;
  assign wr_ctrl = wr_i && (addr_i == csm_pkg::REG_CTRL);
  // Save needs a slot number; selector value zero means default, which is read-only [R09]
  assign do_save = wr_ctrl && wdata_i[csm_pkg::CTRL_SAVE] && (state == csm_pkg::CSM_IDLE)
    && (wdata_i[csm_pkg::CTRL_SEL_LO +: 2] != csm_pkg::SEL_DEFAULT);

  // Source word for a copy: default profile from ROM or a user slot [R11] [R15]
  always_comb
  begin
    if (copy_src == csm_pkg::SEL_DEFAULT)
      src_word = fac_word;
    else
      src_word = slot[copy_src - 2'h1][word_idx];
  end

  // Control path: selectors, commands, copy sequencer
  always_comb
  begin
    next_state = state;
    next_copy_src = copy_src;
    next_word_idx = word_idx;
    next_reject = reject;
    next_user_sel = user_sel;
    next_fac_sel = fac_sel;
    next_boot_sel = boot_sel;
    next_edit_addr = edit_addr;
    refused = 1'b0;
    unique case (state)
      csm_pkg::CSM_BOOT:
      begin
        next_copy_src = boot_sel; // [R12]
        next_word_idx = 2'h0;
        next_state = csm_pkg::CSM_COPY;
      end
      csm_pkg::CSM_COPY:
      begin
        next_word_idx = word_idx + 2'h1;
        if (word_idx == 2'(NW - 1))
          next_state = csm_pkg::CSM_IDLE;
      end
      csm_pkg::CSM_IDLE:
      begin
        if (wr_ctrl)
        begin
          next_user_sel = wdata_i[csm_pkg::CTRL_SEL_LO +: 2];
          next_boot_sel = wdata_i[csm_pkg::CTRL_BOOT_LO +: 2]; // [R17]
          if (wdata_i[csm_pkg::CTRL_LOAD])
          begin
            if (idle)
            begin
              next_copy_src = wdata_i[csm_pkg::CTRL_SEL_LO +: 2]; // [R15]
              next_word_idx = 2'h0;
              next_state = csm_pkg::CSM_COPY;
            end
            else
              refused = 1'b1; // [R16] [R18]
          end
          if (wdata_i[csm_pkg::CTRL_SETFAC])
          begin
            // Encoding 3 is not a profile and is ignored
            if (!idle)
              refused = 1'b1; // [R14] [R18]
            else if (wdata_i[csm_pkg::CTRL_FAC_LO +: 2] != 2'h3)
              next_fac_sel = wdata_i[csm_pkg::CTRL_FAC_LO +: 2];
          end
        end
      end
    endcase
    // A refusal in the clearing cycle wins over the clear, so no refused request goes unreported [R18]
    if (refused)
      next_reject = 1'b1;
    else if (wr_ctrl && wdata_i[csm_pkg::CTRL_CLRERR])
      next_reject = 1'b0;
    if (wr_i && (addr_i == csm_pkg::REG_WADDR))
      next_edit_addr = wdata_i[3:0];
  end

  // Read mux answers the cycle after the strobe
  always_comb
  begin
    next_rdata = 16'h0000;
    if (rd_i)
    begin
      unique case (addr_i)
        csm_pkg::REG_CTRL: next_rdata = {10'h000, fac_sel, boot_sel, user_sel};
        csm_pkg::REG_STATUS: next_rdata = {13'h0000, busy_i, state == csm_pkg::CSM_IDLE, reject};
        csm_pkg::REG_WADDR: next_rdata = {12'h000, edit_addr};
        csm_pkg::REG_WDATA: next_rdata = active[edit_addr[1:0]];
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Volatile registers, rebuilt at reset [R01]
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= csm_pkg::CSM_BOOT;
      copy_src <= csm_pkg::SEL_DEFAULT;
      word_idx <= 2'h0;
      reject <= 1'b0;
      user_sel <= csm_pkg::SEL_DEFAULT;
      edit_addr <= csm_pkg::CTRL_RESET;
    end
    else if (ce_i)
    begin
      state <= next_state;
      copy_src <= next_copy_src;
      word_idx <= next_word_idx;
      reject <= next_reject;
      user_sel <= next_user_sel;
      edit_addr <= next_edit_addr;
    end
  end

  // Active words: copy engine or software edits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NW; i++)
        active[i] <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (state == csm_pkg::CSM_COPY)
      begin
        // Table word is not in any stored set, so it returns to its reset value [R08]
        if (word_idx == csm_pkg::WORD_LUT)
          active[word_idx] <= csm_pkg::LUT_RESET;
        else
          active[word_idx] <= src_word;
      end
      else if (wr_i && (addr_i == csm_pkg::REG_WDATA))
        active[edit_addr[1:0]] <= wdata_i;
    end
  end

  // Persistent store: survives reset_i, cleared only by nv_init_i [R06] [R07]
  always_ff @(posedge clk_i)
  begin
    if (nv_init_i)
    begin
      fac_sel <= csm_pkg::FAC_STANDARD; // [R13]
      boot_sel <= csm_pkg::SEL_DEFAULT;
      for (int s = 0; s < NS; s++)
        for (int i = 0; i < NW; i++)
          slot[s][i] <= 16'h0000;
    end
    else if (ce_i && !reset_i)
    begin
      fac_sel <= next_fac_sel;
      boot_sel <= next_boot_sel;
      if (do_save)
      begin
        // Every word replaced; table word stored as its reset value [R10] [R08] [R09]
        for (int i = 0; i < NW; i++)
          slot[wdata_i[csm_pkg::CTRL_SEL_LO +: 2] - 2'h1][i] <=
            (i == int'(csm_pkg::WORD_LUT)) ? csm_pkg::LUT_RESET : active[i];
      end
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      gain_o <= 16'h0000;
      gain_auto_o <= 16'h0000;
      expo_auto_o <= 16'h0000;
      lut_o <= 16'h0000;
      ready_o <= 1'b0;
      reject_o <= 1'b0;
      rdata_o <= 16'h0000;
    end
    else if (ce_i)
    begin
      gain_o <= active[csm_pkg::WORD_GAIN];
      gain_auto_o <= active[csm_pkg::WORD_GAIN_AUTO];
      expo_auto_o <= active[csm_pkg::WORD_EXPO_AUTO];
      lut_o <= active[csm_pkg::WORD_LUT];
      ready_o <= (next_state == csm_pkg::CSM_IDLE);
      reject_o <= next_reject;
      rdata_o <= next_rdata;
    end
  end

  // Checks
  busy_load_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R16]
    ce_i && wr_ctrl && wdata_i[csm_pkg::CTRL_LOAD] && busy_i && state == csm_pkg::CSM_IDLE
    |=> state != csm_pkg::CSM_COPY)
    else $error("load accepted while busy");
  busy_fac_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
    ce_i && busy_i |=> $stable(fac_sel))
    else $error("default choice changed while busy");
  reject_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R18]
    ce_i && wr_ctrl && busy_i && wdata_i[csm_pkg::CTRL_LOAD] && state == csm_pkg::CSM_IDLE |=> reject)
    else $error("refused request not flagged");
  boot_copy_a: assert property (@(posedge clk_i) // [R12]
    reset_i ##1 !reset_i && ce_i [*6] |-> state == csm_pkg::CSM_IDLE)
    else $error("boot copy did not finish");
  lut_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R08]
    ce_i && state == csm_pkg::CSM_COPY && word_idx == csm_pkg::WORD_LUT |=> active[3] == csm_pkg::LUT_RESET)
    else $error("table word kept over copy");
  high_gain_a: assert property (@(posedge clk_i) // [R04]
    fac_sel == csm_pkg::FAC_HIGH_GAIN && word_idx == csm_pkg::WORD_GAIN |-> fac_word == csm_pkg::GAIN_6DB)
    else $error("high gain profile wrong");
  auto_prof_a: assert property (@(posedge clk_i) // [R05]
    fac_sel == csm_pkg::FAC_AUTO && word_idx == csm_pkg::WORD_EXPO_AUTO |-> fac_word == csm_pkg::AUTO_CONT)
    else $error("auto profile wrong");
  save_copy_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
    ce_i && do_save && wdata_i[1:0] == 2'h1 |=> slot[0][0] == $past(active[0]))
    else $error("save did not replace slot");
  // Refusal, sequencer, profile and persistence checks
  fac_refuse_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
    ce_i && wr_ctrl && busy_i && wdata_i[csm_pkg::CTRL_SETFAC] && state == csm_pkg::CSM_IDLE |=> reject)
    else $error("refused default change not flagged");
  clear_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R18]
    ce_i && wr_ctrl && wdata_i[csm_pkg::CTRL_CLRERR] && !refused |=> !reject)
    else $error("reject flag not cleared");
  load_start_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R15]
    ce_i && idle && wr_ctrl && wdata_i[csm_pkg::CTRL_LOAD]
    |=> state == csm_pkg::CSM_COPY && word_idx == 2'h0 && copy_src == $past(wdata_i[csm_pkg::CTRL_SEL_LO +: 2]))
    else $error("load did not start the copy");
  copy_end_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
    ce_i && state == csm_pkg::CSM_COPY && word_idx == 2'(NW - 1) |=> state == csm_pkg::CSM_IDLE)
    else $error("copy did not end after last word");
  boot_src_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
    ce_i && state == csm_pkg::CSM_BOOT |=> state == csm_pkg::CSM_COPY && copy_src == $past(boot_sel))
    else $error("boot copy took the wrong source");
  nv_keep_a: assert property (@(posedge clk_i) // [R06]
    reset_i && !nv_init_i |=> $stable(fac_sel) && $stable(boot_sel))
    else $error("persistent choice lost over reset");
  std_prof_a: assert property (@(posedge clk_i) // [R03]
    fac_sel == csm_pkg::FAC_STANDARD && word_idx == csm_pkg::WORD_GAIN_AUTO |-> fac_word == csm_pkg::AUTO_OFF)
    else $error("standard profile has an auto function on");
  slot_lut_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R08]
    ce_i && do_save |=> slot[0][csm_pkg::WORD_LUT] == csm_pkg::LUT_RESET
    && slot[1][csm_pkg::WORD_LUT] == csm_pkg::LUT_RESET && slot[2][csm_pkg::WORD_LUT] == csm_pkg::LUT_RESET)
    else $error("table word stored in a user slot");
  ready_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
    ce_i |=> ready_o == (state == csm_pkg::CSM_IDLE))
    else $error("ready flag out of step with sequencer");
endmodule

// file: test/csm_testbench.sv
// Purpose: self-checking bench for the configuration set manager
// Assumes: register port answers reads one cycle later; ready_o marks the copy engine idle
// Notes: expected read data are queued by the driver and matched by a separate monitor
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [15:0] v; string n;} csm_note_type;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic nv_init_i = 1'b1;
  logic busy_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_seen = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o, gain_o, gain_auto_o, expo_auto_o, lut_o;
  logic ready_o, reject_o;
  logic [1:0] boot = 2'h0;
  logic [15:0] sv [4];
  csm_note_type notes [$];
  integer seed = 32'h62d4;
  integer bad_count = 0;
  integer compares = 0;
  integer cycles = 0;

  csm_manager u_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .nv_init_i(nv_init_i), .busy_i(busy_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gain_o(gain_o),
    .gain_auto_o(gain_auto_o), .expo_auto_o(expo_auto_o), .lut_o(lut_o), .ready_o(ready_o), .reject_o(reject_o));

  // 50 MHz clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Monitor: read data stand only in the cycle after the strobe; a hang is cut at 5000 cycles
  always @(posedge clk_i)
  begin
    csm_note_type e;
    cycles <= cycles + 1;
    rd_seen <= rd_i;
    if (rd_seen)
    begin
      e = notes.pop_front();
      check(e.n, rdata_o, e.v);
    end
    if (cycles == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // Bus cycles: one idle edge between strobes so no signal is assigned twice in a time step
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] e, input string n);
    notes.push_back('{e, n});
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task wt;
    repeat (3) @(posedge clk_i);
    while (ready_o !== 1'b1) @(posedge clk_i);
  endtask

  // Command bits: 3 clear reject, 2 set default, 1 load, 0 save
  task ctl(input logic [1:0] sel, input logic [1:0] fac, input logic [3:0] cmd);
    wr(csm_pkg::REG_CTRL, {6'h00, cmd, fac, boot, sel});
    wt();
  endtask

  task setw(input logic [1:0] i, input logic [15:0] d);
    wr(csm_pkg::REG_WADDR, {14'h0000, i});
    wr(csm_pkg::REG_WDATA, d);
  endtask

  task chk_set(input logic [15:0] w [4]);
    for (int i = 0; i < 4; i++)
    begin
      wr(csm_pkg::REG_WADDR, 16'(i));
      rd(csm_pkg::REG_WDATA, w[i], $sformatf("active word %0d", i));
    end
    repeat (2) @(posedge clk_i);
    check("gain_o", gain_o, w[0]);
    check("gain_auto_o", gain_auto_o, w[1]);
    check("expo_auto_o", expo_auto_o, w[2]);
    check("lut_o", lut_o, w[3]);
  endtask

  // Main sequence: power-up, factory profiles, save and load, refusals, reboot from a slot
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    nv_init_i <= 1'b0;
    wt();
    rd(csm_pkg::REG_CTRL, 16'h0000, "ctrl after power-up");
    chk_set('{csm_pkg::GAIN_LOW, csm_pkg::AUTO_OFF, csm_pkg::AUTO_OFF, csm_pkg::LUT_RESET});
    for (int f = 1; f < 4; f++)
    begin
      ctl(2'h0, 2'(f % 3), 4'h4);
      ctl(2'h0, 2'h0, 4'h2);
      sv[0] = (f == 1) ? csm_pkg::GAIN_6DB : csm_pkg::GAIN_LOW;
      sv[1] = (f == 2) ? csm_pkg::AUTO_CONT : csm_pkg::AUTO_OFF;
      sv[2] = sv[1];
      sv[3] = csm_pkg::LUT_RESET;
      chk_set(sv);
    end
    // Second save to the same slot must replace the first completely
    boot = 2'h2;
    for (int k = 0; k < 2; k++)
    begin
      sv[0] = 16'($random(seed));
      sv[1] = $random(seed) & 1 ? csm_pkg::AUTO_CONT : csm_pkg::AUTO_OFF;
      sv[2] = $random(seed) & 1 ? csm_pkg::AUTO_CONT : csm_pkg::AUTO_OFF;
      sv[3] = 16'($random(seed)) | 16'h0001;
      for (int i = 0; i < 4; i++) setw(2'(i), sv[i]);
      ctl(2'h2, 2'h0, 4'h1);
    end
    sv[3] = csm_pkg::LUT_RESET;
    setw(2'h0, ~sv[0]);
    ctl(2'h2, 2'h0, 4'h2);
    chk_set(sv);
    ctl(2'h1, 2'h0, 4'h1);
    ctl(2'h3, 2'h0, 4'h1);
    // Busy: load and default change are refused and flagged
    busy_i <= 1'b1;
    setw(2'h0, ~sv[0]);
    ctl(2'h2, 2'h0, 4'h2);
    ctl(2'h2, 2'h1, 4'h4);
    check("reject_o", {15'h0000, reject_o}, 16'h0001);
    rd(csm_pkg::REG_STATUS, 16'h0007, "status while busy");
    rd(csm_pkg::REG_CTRL, 16'h000a, "ctrl after refused default");
    chk_set('{~sv[0], sv[1], sv[2], sv[3]});
    // Clear and a fresh refusal in one write: the refusal must win
    ctl(2'h2, 2'h0, 4'ha);
    check("reject_o", {15'h0000, reject_o}, 16'h0001);
    busy_i <= 1'b0;
    ctl(2'h2, 2'h0, 4'h8);
    rd(csm_pkg::REG_STATUS, 16'h0002, "status after clear");
    // Reboot: slot 2 is the boot set, high gain default must survive
    ctl(2'h2, 2'h1, 4'h4);
    setw(2'h3, 16'h00a5);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    wt();
    chk_set(sv);
    // Load of the default set: ready drops for the four copy cycles
    wr(csm_pkg::REG_CTRL, {6'h00, 4'h2, 2'h0, boot, 2'h0});
    repeat (4) @(posedge clk_i);
    check("ready_o during copy", {15'h0000, ready_o}, 16'h0000);
    @(posedge clk_i);
    check("ready_o after copy", {15'h0000, ready_o}, 16'h0001);
    chk_set('{csm_pkg::GAIN_6DB, csm_pkg::AUTO_OFF, csm_pkg::AUTO_OFF, csm_pkg::LUT_RESET});
    ctl(2'h3, 2'h0, 4'h2);
    chk_set(sv);
    // Writes while the clock enable is low must leave the active set alone
    ce_i <= 1'b0;
    wr(csm_pkg::REG_WDATA, 16'h5a5a);
    ce_i <= 1'b1;
    rd(csm_pkg::REG_WDATA, csm_pkg::LUT_RESET, "table word after frozen write");
    repeat (2) @(posedge clk_i);
    complete_run();
  end
endmodule
